// File: dv/bgc_regs_sva.sv
// Port checks of the bridge general control bank
`timescale 1ns/10ps
`default_nettype none
module bgc_regs_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_fundamental_reset_in,
    input wire logic i_global_reset_in,
    input wire logic i_aux_rst,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic i_in_d3,
    input wire logic i_l2_wake_req,
    input wire logic o_cfg_rvalid,
    input wire logic o_burst_prefetch_off,
    input wire logic [2:0] o_advertised_standby_exit_delay,
    input wire logic [2:0] o_advertised_sleep_exit_delay,
    input wire logic [11:0] o_aer_next_cap,
    input wire logic o_secondary_clock_stop_en,
    input wire logic o_secondary_clk_run,
    input wire logic o_wake_assert,
    input wire logic o_beacon_assert,
    input wire logic [1:0] o_min_power_scale,
    input wire logic [7:0] o_min_power_value
);
    // ------
    // Properties
    // ------
    // Pin resets are synced, so writes are judged only well clear of them
    wire logic pin_rst = i_fundamental_reset_in | i_global_reset_in;
    wire logic quiet = !(pin_rst | i_aux_rst);
    wire logic wr_gc = i_cfg_wr && i_cfg_addr[7:2] == 6'h35 && i_cfg_be == 4'hf;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_quiet; quiet[*5]; endsequence
    sequence s_wr; s_quiet ##0 wr_gc; endsequence
    property p_fld; s_wr |=> {o_burst_prefetch_off, o_min_power_scale, o_min_power_value} ==
        $past({i_cfg_wdata[19], i_cfg_wdata[9:0]}); endproperty
    a_fld: assert property (p_fld) else $error("field outputs");
    property p_lat; s_wr |=> {o_advertised_standby_exit_delay, o_advertised_sleep_exit_delay} ==
        $past(i_cfg_wdata[18:13]); endproperty
    a_lat: assert property (p_lat) else $error("latency mirror");
    property p_cap; s_wr |=> o_aer_next_cap == ($past(i_cfg_wdata[12]) ? 12'h150 : 12'h000); endproperty
    a_cap: assert property (p_cap) else $error("next offset");
    property p_pin; pin_rst[*5] |-> {o_advertised_standby_exit_delay, o_advertised_sleep_exit_delay} == 6'h36 &&
        {o_burst_prefetch_off, o_aer_next_cap, o_min_power_scale, o_min_power_value} == 23'h0; endproperty
    a_pin: assert property (p_pin) else $error("pin reset defaults");
    property p_keep; (pin_rst && !i_aux_rst)[*4] |=> i_aux_rst || $stable(o_secondary_clock_stop_en); endproperty
    a_keep: assert property (p_keep) else $error("sticky lost");
    property p_clk; ($stable(i_in_d3) && $stable(o_secondary_clock_stop_en))[*4] |->
        o_secondary_clk_run == !(i_in_d3 && o_secondary_clock_stop_en); endproperty
    a_clk: assert property (p_clk) else $error("clock stop");
    property p_wake; $stable(i_l2_wake_req)[*4] |->
        o_wake_assert == i_l2_wake_req && !(o_beacon_assert && !i_l2_wake_req); endproperty
    a_wake: assert property (p_wake) else $error("wake path");
    property p_rd; i_cfg_rd |=> o_cfg_rvalid ##1 (!o_cfg_rvalid || $past(i_cfg_rd)); endproperty
    a_rd: assert property (p_rd) else $error("read answer");
endmodule : bgc_regs_sva
bind bgc_regs bgc_regs_sva u_sva (.*);
`default_nettype wire

// File: dv/bgc_regs_tb.sv
// Self-checking testbench of the bridge general control bank
`timescale 1ns/10ps
`default_nettype none
module bgc_regs_tb;
    // ------
    // Design, clock and checks
    // ------
    localparam logic [31:0] RV = bgc_pkg::GEN_CTRL_RST;
    logic i_clk, i_rst, i_fundamental_reset_in, i_global_reset_in, i_aux_rst, i_cfg_wr, i_cfg_rd;
    logic i_in_d3, i_l2_wake_req, o_cfg_rvalid, o_burst_prefetch_off, o_single_dword_fetch;
    logic o_secondary_clock_stop_en, o_secondary_clk_run, o_wake_assert, o_beacon_assert;
    logic [7:0] i_cfg_addr, o_min_power_value;
    logic [3:0] i_cfg_be;
    logic [31:0] i_cfg_wdata, o_cfg_rdata, d;
    logic [2:0] o_advertised_standby_exit_delay, o_advertised_sleep_exit_delay;
    logic [11:0] o_aer_next_cap;
    logic [1:0] o_min_power_scale;
    logic [31:0] exp_q[$];
    int errors, n_tests;
    bgc_regs u_dut (.*);
    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp) errors++;
    endtask : chk
    // Field outputs against the expected word w
    task automatic chk_out(input logic [31:0] w);
        chk({2'h0, o_burst_prefetch_off, o_single_dword_fetch, o_advertised_standby_exit_delay,
            o_advertised_sleep_exit_delay, o_aer_next_cap, o_min_power_scale, o_min_power_value},
            {2'h0, w[19], w[19], w[18:13], (w[12] ? 12'h150 : 12'h000), w[9:0]});
    endtask : chk_out
    // Wait edges, then step just past the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc
    // One-cycle request; a read notes its expected word first
    task automatic op(input logic rw, input logic [7:0] a, input logic [3:0] b, input logic [31:0] w);
        cyc(1);
        if (!rw) exp_q.push_back(w);
        {i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {rw, !rw, a, b, w};
        cyc(1);
        {i_cfg_wr, i_cfg_rd} = 2'h0;
    endtask : op
    // Each answered read takes the oldest note
    always @(posedge i_clk) begin
        if (o_cfg_rvalid === 1'b1 && exp_q.size() == 0) errors++;
        else if (o_cfg_rvalid === 1'b1) chk(o_cfg_rdata, exp_q.pop_front());
    end
    task automatic results;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    // Hang guard
    initial begin
        #500000 errors++;
        results();
    end
    // Main sequence
    initial begin
        errors = 0;
        n_tests = 0;
        {i_rst, i_aux_rst, i_fundamental_reset_in, i_global_reset_in, i_cfg_wr, i_cfg_rd} = 6'h30;
        {i_in_d3, i_l2_wake_req, i_cfg_addr, i_cfg_be, i_cfg_wdata} = 46'h0000_0000_0000;
        void'($urandom(32'h0000_17df));
        cyc(8);
        {i_rst, i_aux_rst} = 2'h0;
        // Reset words, an unmapped place and the reserved lanes
        op(0, 8'hd4, 4'hf, RV);
        op(0, 8'h40, 4'hf, 32'h0000_0000);
        op(1, 8'hd8, 4'h3, 32'h0000_0000);
        op(1, 8'hd8, 4'h4, 32'h00ff_0000);
        op(0, 8'hd8, 4'hf, 32'h0000_0000);
        // Every latency and scale code, both next offsets, the rest random
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            d[18:8] = {i[2:0], ~i[2:0], i[0], d[11:10], i[1:0]};
            op(1, 8'hd4, 4'hf, d);
            chk_out(d);
            op(0, 8'hd4, 4'hf, {RV[31:20], d[19:0]});
        end
        // Pin resets restore defaults yet keep the sticky pair
        for (int k = 1; k < 3; k++) begin
            op(1, 8'hd4, 4'hf, 32'h000f_fc00);
            {i_global_reset_in, i_fundamental_reset_in} = k[1:0];
            cyc(6);
            {i_global_reset_in, i_fundamental_reset_in} = 2'h0;
            cyc(4);
            chk_out(RV);
            op(0, 8'hd4, 4'hf, RV | 32'h0000_0c00);
        end
        // Sticky pair set: D3 stops clocks, wake brings the beacon
        {i_in_d3, i_l2_wake_req} = 2'h3;
        cyc(5);
        chk({29'h0, o_secondary_clk_run, o_wake_assert, o_beacon_assert}, 32'h0000_0003);
        i_aux_rst = 1'b1;
        cyc(1);
        i_aux_rst = 1'b0;
        cyc(5);
        chk({29'h0, o_secondary_clk_run, o_wake_assert, o_beacon_assert}, 32'h0000_0006);
        op(0, 8'hd4, 4'hf, RV);
        // Pins idle first: reset clears the synchronisers to their idle level
        {i_in_d3, i_l2_wake_req} = 2'h0;
        cyc(4);
        // Power-on reset again in mid-run
        op(1, 8'hd4, 4'hf, 32'h000f_fc00);
        i_rst = 1'b1;
        cyc(2);
        i_rst = 1'b0;
        op(0, 8'hd4, 4'hf, RV | 32'h0000_0c00);
        for (int j = 0; j < 10 && exp_q.size() != 0; j++) cyc(1);
        if (exp_q.size() != 0) errors++;
        results();
    end
endmodule : bgc_regs_tb
`default_nettype wire

// File: src/bgc_pkg.sv
// Package with offsets, field positions and reset values of the bridge general control bank
package bgc_pkg;
    // ------------------------------------------------------------
    // Configuration offsets (byte addresses in config space)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_GEN_CTRL = 8'hd4;
    localparam logic [7:0] OFF_VRSV_A = 8'hd8;
    localparam logic [7:0] OFF_VRSV_B = 8'hd9;
    localparam logic [7:0] OFF_VRSV_STAT = 8'hda;
    localparam logic [11:0] OFF_AER_HDR = 12'h102;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] GEN_CTRL_RST = 32'h8206_c000;
    localparam logic [7:0] VRSV_RST = 8'h00;
    // ------------------------------------------------------------
    // Field positions of the general control word
    // ------------------------------------------------------------
    localparam int BIT_PREFETCH_OFF = 19;
    localparam int STBY_HI = 18;
    localparam int STBY_LO = 16;
    localparam int SLEEP_HI = 15;
    localparam int SLEEP_LO = 13;
    localparam int BIT_CHAN_CAP = 12;
    localparam int BIT_CLK_STOP = 11;
    localparam int BIT_BEACON = 10;
    localparam int SCALE_HI = 9;
    localparam int SCALE_LO = 8;
    localparam int MINPWR_HI = 7;
    localparam int MINPWR_LO = 0;
    // Low twenty bits are owned here; the rest is held read-only at reset value
    localparam logic [31:0] GEN_CTRL_WMASK = 32'h000f_ffff;
    localparam logic [31:0] STICKY_MASK = 32'h0000_0c00;
    // ------------------------------------------------------------
    // Device capability mirror positions and next-capability offsets
    // ------------------------------------------------------------
    localparam int DEVCAP_STBY_LO = 6;
    localparam int DEVCAP_SLEEP_LO = 9;
    localparam logic [11:0] NEXT_CAP_NONE = 12'h000;
    localparam logic [11:0] NEXT_CAP_CHAN = 12'h150;
    // Minimum power scale encodings
    typedef enum logic [1:0] {
        BGC_SCALE_1 = 2'b00,
        BGC_SCALE_0P1 = 2'b01,
        BGC_SCALE_0P01 = 2'b10,
        BGC_SCALE_0P001 = 2'b11
    } bgc_scale_t;
endpackage : bgc_pkg

// File: src/bgc_regs.sv
// Bridge general control register bank with vendor-reserved registers
// What this block does
// - Prefetch off fetches one dword per burst
// - Standby exit field mirrored into capabilities 8:6
// - Standby codes power-of-two, default code 110
// - Sleep exit field mirrored into capabilities 11:9
// - Bit 12 picks next offset 000h or 150h
// - Bit 11 stops secondary clocks in D3
// - Bit 10 adds beacon to wake from L2
// - Scale field selects minimum power multiplier
// - Minimum power value resets to 00h
// - Non-sticky fields reset by three resets
// - Clock stop and beacon bits are sticky
// - DAh is read-only and reads 00h
// - Vendor registers cleared by three resets
// - General control at D4h, reset 8206C000h
`timescale 1ns/10ps
`default_nettype none
module bgc_regs (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_fundamental_reset_in,
    input wire logic i_global_reset_in,
    input wire logic i_aux_rst,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic i_in_d3,
    input wire logic i_l2_wake_req,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    output logic o_burst_prefetch_off,
    output logic o_single_dword_fetch,
    output logic [2:0] o_advertised_standby_exit_delay,
    output logic [2:0] o_advertised_sleep_exit_delay,
    output logic [11:0] o_aer_next_cap,
    output logic o_secondary_clock_stop_en,
    output logic o_secondary_clk_run,
    output logic o_wake_assert,
    output logic o_beacon_assert,
    output logic [1:0] o_min_power_scale,
    output logic [7:0] o_min_power_value
);
    // ------------------------------------------------------------
    // Reset combination and synchronisers
    // ------------------------------------------------------------
    // Slot of each pin in the synchroniser vector
    localparam int PIN_FUND_RST = 0;
    localparam int PIN_GLOB_RST = 1;
    localparam int PIN_D3 = 2;
    localparam int PIN_WAKE = 3;
    localparam int N_PINS = 4;

    logic [N_PINS-1:0] pin_raw;
    logic [N_PINS-1:0] pin_sync;
    logic d3_sync;
    logic wake_sync;
    logic bank_clr;

    // Gather the asynchronous pins in one vector
    assign pin_raw[PIN_FUND_RST] = i_fundamental_reset_in;
    assign pin_raw[PIN_GLOB_RST] = i_global_reset_in;
    assign pin_raw[PIN_D3] = i_in_d3;
    assign pin_raw[PIN_WAKE] = i_l2_wake_req;

    // One two-flop synchroniser per pin; only stage two is read
    for (genvar g = 0; g < N_PINS; g++) begin : g_sync
        logic s1_ff;
        logic s2_ff;
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                s1_ff <= 1'b0;
                s2_ff <= 1'b0;
            end else begin
                s1_ff <= pin_raw[g];
                s2_ff <= s1_ff;
            end
        end
        assign pin_sync[g] = s2_ff;
    end

    // Synchronised levels used by the field effects below
    assign d3_sync = pin_sync[PIN_D3];
    assign wake_sync = pin_sync[PIN_WAKE];

    // i_rst stands for the power-on reset; pins clear the bank synchronously
    // Cost: a pin reset shorter than one clock may be missed
    assign bank_clr = pin_sync[PIN_FUND_RST] | pin_sync[PIN_GLOB_RST];

    // ------------------------------------------------------------
    // Address decode and byte-enable merge
    // ------------------------------------------------------------
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : be_mask

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : hit

    // D8h..DAh share one dword; lanes 0..2 are the three vendor bytes
    logic wr_gen;
    logic wr_vrsv;
    logic [31:0] wmask;
    assign wr_gen = i_cfg_wr & hit(i_cfg_addr, bgc_pkg::OFF_GEN_CTRL);
    assign wr_vrsv = i_cfg_wr & hit(i_cfg_addr, bgc_pkg::OFF_VRSV_A);
    assign wmask = be_mask(i_cfg_be);

    // ------------------------------------------------------------
    // Non-sticky general control fields
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [7:0] vrsv_a_ff;
    logic [7:0] vrsv_b_ff;
    logic [7:0] nxt_vrsv_a;
    logic [7:0] nxt_vrsv_b;
    localparam logic [31:0] NS_MASK = bgc_pkg::GEN_CTRL_WMASK & ~bgc_pkg::STICKY_MASK;

    // Upper bits are outside this bank, so they stay at their reset value
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_vrsv_a = vrsv_a_ff;
        nxt_vrsv_b = vrsv_b_ff;
        if (bank_clr) begin
            nxt_ctrl = bgc_pkg::GEN_CTRL_RST;
            nxt_vrsv_a = bgc_pkg::VRSV_RST;
            nxt_vrsv_b = bgc_pkg::VRSV_RST;
        end else begin
            if (wr_gen) begin
                nxt_ctrl = (ctrl_ff & ~(wmask & NS_MASK)) | (i_cfg_wdata & wmask & NS_MASK);
            end
            // Writable though software is expected to leave them at zero
            if (wr_vrsv && i_cfg_be[0]) begin
                nxt_vrsv_a = i_cfg_wdata[7:0];
            end
            if (wr_vrsv && i_cfg_be[1]) begin
                nxt_vrsv_b = i_cfg_wdata[15:8];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_ff <= bgc_pkg::GEN_CTRL_RST;
            vrsv_a_ff <= bgc_pkg::VRSV_RST;
            vrsv_b_ff <= bgc_pkg::VRSV_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            vrsv_a_ff <= nxt_vrsv_a;
            vrsv_b_ff <= nxt_vrsv_b;
        end
    end

    // ------------------------------------------------------------
    // Sticky bits live in their own holder on aux power
    // ------------------------------------------------------------
    bgc_sticky_if sif ();

    // Writes during a pin reset are dropped here as in the rest of the bank
    assign sif.wr_en = wr_gen & i_cfg_be[1] & ~bank_clr;
    assign sif.clk_stop_wdata = i_cfg_wdata[bgc_pkg::BIT_CLK_STOP];
    assign sif.beacon_wdata = i_cfg_wdata[bgc_pkg::BIT_BEACON];

    bgc_sticky_hold u_sticky (
        .i_clk(i_clk),
        .i_aux_rst(i_aux_rst),
        .sif(sif)
    );

    logic [31:0] ctrl_view;
    always_comb begin
        ctrl_view = ctrl_ff;
        ctrl_view[bgc_pkg::BIT_CLK_STOP] = sif.clk_stop;
        ctrl_view[bgc_pkg::BIT_BEACON] = sif.beacon;
    end

    // ------------------------------------------------------------
    // Read path: one-cycle registered answer
    // ------------------------------------------------------------
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    // Unmapped offsets read zero; DAh is a constant zero byte
    always_comb begin
        nxt_rvalid = i_cfg_rd;
        nxt_rdata = '0;
        if (i_cfg_rd && hit(i_cfg_addr, bgc_pkg::OFF_GEN_CTRL)) begin
            nxt_rdata = ctrl_view;
        end else if (i_cfg_rd && hit(i_cfg_addr, bgc_pkg::OFF_VRSV_A)) begin
            nxt_rdata = {8'h00, bgc_pkg::VRSV_RST, vrsv_b_ff, vrsv_a_ff};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign o_cfg_rdata = rdata_ff;
    assign o_cfg_rvalid = rvalid_ff;

    // ------------------------------------------------------------
    // Field effects on the rest of the bridge
    // ------------------------------------------------------------
    // Set: one dword per burst read; clear: up to cache line end
    assign o_burst_prefetch_off = ctrl_ff[bgc_pkg::BIT_PREFETCH_OFF];
    assign o_single_dword_fetch = ctrl_ff[bgc_pkg::BIT_PREFETCH_OFF];

    // Mirrors are wires, so a write is visible on the very next read
    assign o_advertised_standby_exit_delay =
        ctrl_ff[bgc_pkg::STBY_HI:bgc_pkg::STBY_LO];
    assign o_advertised_sleep_exit_delay =
        ctrl_ff[bgc_pkg::SLEEP_HI:bgc_pkg::SLEEP_LO];

    // Next pointer of the error reporting header
    assign o_aer_next_cap = ctrl_ff[bgc_pkg::BIT_CHAN_CAP] ?
        bgc_pkg::NEXT_CAP_CHAN : bgc_pkg::NEXT_CAP_NONE;

    // Clocks gated only when enabled and in D3
    assign o_secondary_clock_stop_en = sif.clk_stop;
    assign o_secondary_clk_run = ~(sif.clk_stop & d3_sync);

    // Wake always used; beacon added only when enabled
    assign o_wake_assert = wake_sync;
    assign o_beacon_assert = wake_sync & sif.beacon;

    // Scale and value reported raw; consumer applies the multiplier
    assign o_min_power_scale = ctrl_ff[bgc_pkg::SCALE_HI:bgc_pkg::SCALE_LO];
    assign o_min_power_value = ctrl_ff[bgc_pkg::MINPWR_HI:bgc_pkg::MINPWR_LO];

    // ------------------------------------------------------------
    // Usage notes for integrators
    // ------------------------------------------------------------
    // Field map of the low twenty bits of the control word:
    //   19     burst prefetch off
    //   18:16  standby exit delay select, mirrored to capabilities
    //   15:13  sleep exit delay select, mirrored to capabilities
    //   12     channel capability expose, steers next pointer
    //   11     secondary clock stop enable, sticky
    //   10     beacon enable, sticky
    //   9:8    minimum power scale
    //   7:0    minimum power value
    // Bits 31:20 read back their reset value and ignore writes.
    // The sticky pair lives in its own holder so that only the
    // auxiliary reset clears it; the bank resets leave it alone.
    // Pin resets act through the synchronisers, so a write that
    // lands within two clocks of a pin rising may still take effect
    // before the clear; software should not write during reset.
    // The read answer always comes exactly one clock after the
    // read strobe and stands for that single clock only.
    // Lane 3 of the vendor dword and the status lane are read-only.
endmodule : bgc_regs
`default_nettype wire

// File: src/bgc_sticky_hold.sv
// Sticky control bits kept alive on auxiliary power
`timescale 1ns/10ps
`default_nettype none
module bgc_sticky_hold (
    input wire logic i_clk,
    input wire logic i_aux_rst,
    bgc_sticky_if.holder sif
);
    logic clk_stop_ff;
    logic beacon_ff;
    logic nxt_clk_stop;
    logic nxt_beacon;

    // Next value: load on a write only
    always_comb begin
        nxt_clk_stop = clk_stop_ff;
        nxt_beacon = beacon_ff;
        if (sif.wr_en) begin
            nxt_clk_stop = sif.clk_stop_wdata;
            nxt_beacon = sif.beacon_wdata;
        end
    end

    // Only the aux-domain reset clears these, bank resets do not
    always_ff @(posedge i_clk or posedge i_aux_rst) begin
        if (i_aux_rst) begin
            clk_stop_ff <= bgc_pkg::GEN_CTRL_RST[bgc_pkg::BIT_CLK_STOP];
            beacon_ff <= bgc_pkg::GEN_CTRL_RST[bgc_pkg::BIT_BEACON];
        end else begin
            clk_stop_ff <= nxt_clk_stop;
            beacon_ff <= nxt_beacon;
        end
    end

    assign sif.clk_stop = clk_stop_ff;
    assign sif.beacon = beacon_ff;
endmodule : bgc_sticky_hold
`default_nettype wire

// File: src/bgc_sticky_if.sv
// Interface carrying the sticky control bits between bank and sticky holder
`timescale 1ns/10ps
`default_nettype none
interface bgc_sticky_if;
    logic wr_en;
    logic clk_stop_wdata;
    logic beacon_wdata;
    logic clk_stop;
    logic beacon;
    modport bank (output wr_en, output clk_stop_wdata, output beacon_wdata, input clk_stop, input beacon);
    modport holder (input wr_en, input clk_stop_wdata, input beacon_wdata, output clk_stop, output beacon);
endinterface : bgc_sticky_if
`default_nettype wire
